// File: ext_pin_model.sv
// Model of the outside pins: the external clock source and the channel pin level.
`timescale 1ns/1ps
`default_nettype none
module ext_pin_model (
  // Control.
  input wire logic run,
  input wire logic level,
  // Timer side.
  input wire logic pin_out,
  input wire logic pin_oe,
  output logic ext_clk,
  output logic pin_level
);
  // A 100 ns period keeps the source under a quarter of the bus rate; it stands low when idle.
  initial ext_clk = 1'b0;
  always #50 ext_clk = run ? ~ext_clk : 1'b0;
  assign pin_level = pin_oe ? pin_out : level;
endmodule : ext_pin_model
`default_nettype wire

// File: tb.sv
// Self-checking bench for the timer/PWM counter core.
`timescale 1ns/1ps
`default_nettype none
module tb
  import timer_core_pkg::*;
;
  logic clk, sys_rst, fsc, ext_clk, pin_lvl, port_data, port_dir, run, pin_out, pin_oe, irq, lvl, chirq;
  logic [7:0] rdata;
  logic [15:0] cnt;
  reg_req_t req;
  int bad_count, checked, cycles;
  timer_pwm_counter_core timer_pwm_counter_core_inst (
    .clk, .sys_rst, .reg_addr(req.addr), .reg_wdata(req.wdata), .reg_wr(req.wr), .reg_rd(req.rd),
    .reg_rdata(rdata), .fixed_system_clock(fsc), .external_timer_clock(ext_clk), .port_data, .port_dir,
    .channel_pin_in(pin_lvl), .channel_pin_out(pin_out), .channel_pin_oe(pin_oe), .counter_value(cnt),
    .overflow_irq(irq), .channel_irq(chirq)
  );
  ext_pin_model ext_pin_model_inst (.run, .level(lvl), .pin_out, .pin_oe, .ext_clk, .pin_level(pin_lvl));
  always #10 clk = ~clk;
  always #100 fsc = ~fsc;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 8000) begin
      bad_count++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    if (bad_count == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input logic ok, input string msg);
    checked++;
    if (!ok) begin
      bad_count++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    req <= '0;
  endtask : wr
  task automatic rd(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk);
    req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    req <= '0;
    @(negedge clk);
    chk((rdata & m) === e, "read data");
  endtask : rd
  task automatic t_reset();
    chk(cnt === 16'h0000 && irq === 1'b0 && pin_oe === 1'b0, "not idle");
    rd(3'h0, 8'hff, 8'h00);
    wr(3'h0, 8'h80);
    wr(3'h6, 8'hff);
    rd(3'h0, 8'hff, 8'h00);
    rd(3'h6, 8'hff, 8'h00);
  endtask : t_reset
  task automatic t_up();
    logic [15:0] mx;
    mx = 16'h0000;
    wr(3'h4, 8'h05);
    wr(3'h1, 8'h00);
    wr(3'h0, 8'h48);
    repeat (20) begin
      @(negedge clk);
      if (cnt > mx) mx = cnt;
    end
    rd(3'h1, 8'hff, 8'h00);
    chk(mx === 16'h0005 && irq === 1'b1, "no wrap");
    rd(3'h0, 8'h80, 8'h80);
    repeat (8) @(posedge clk);
    wr(3'h0, 8'h48);
    wr(3'h0, 8'h40);
    rd(3'h0, 8'hff, 8'hc0);
    wr(3'h0, 8'h40);
    rd(3'h0, 8'hff, 8'h40);
    chk(irq === 1'b0, "irq stuck");
  endtask : t_up
  task automatic t_prescale();
    wr(3'h4, 8'h00);
    for (int p = 0; p < 8; p++) begin
      wr(3'h0, {5'h01, p[2:0]});
      wr(3'h2, 8'h00);
      repeat (8 << p) @(posedge clk);
      @(negedge clk);
      chk(cnt >= 16'h0006 && cnt <= 16'h0009, "divisor");
    end
  endtask : t_prescale
  task automatic t_center();
    logic [15:0] mx, last;
    int dn;
    mx = 16'h0000;
    last = 16'h0000;
    dn = 0;
    wr(3'h4, 8'h03);
    wr(3'h1, 8'h00);
    wr(3'h0, 8'h68);
    repeat (20) begin
      @(negedge clk);
      if (cnt > mx) mx = cnt;
      if (last === 16'h0003 && cnt === 16'h0002) dn++;
      last = cnt;
    end
    chk(mx === 16'h0003 && dn > 0 && irq === 1'b1, "no turn");
  endtask : t_center
  task automatic t_clocks();
    wr(3'h4, 8'h00);
    wr(3'h5, 8'h00);
    run <= 1'b1;
    wr(3'h0, 8'h18);
    wr(3'h1, 8'h00);
    repeat (40) @(posedge clk);
    @(negedge clk);
    chk(cnt >= 16'h0006 && cnt <= 16'h0009, "external");
    run <= 1'b0;
    wr(3'h0, 8'h10);
    wr(3'h1, 8'h00);
    repeat (40) @(posedge clk);
    @(negedge clk);
    chk(cnt >= 16'h0003 && cnt <= 16'h0005, "fixed");
  endtask : t_clocks
  task automatic t_pin();
    wr(3'h4, 8'h10);
    wr(3'h0, 8'h08);
    port_dir <= 1'b1;
    port_data <= 1'b1;
    wr(3'h5, 8'h08);
    @(negedge clk);
    chk(pin_oe === 1'b1 && pin_out === 1'b1, "port");
    port_dir <= 1'b0;
    lvl <= 1'b0;
    wr(3'h5, 8'h09);
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk(pin_oe === 1'b1, "owned pin");
    chk(pin_out === (cnt >= 16'h0010), "pwm level");
    wr(3'h5, 8'h01);
    wr(3'h5, 8'h01);
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk(chirq === 1'b0 && pin_oe === 1'b0, "capture idle");
    @(posedge clk);
    lvl <= 1'b1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk(chirq === 1'b1, "capture edge");
  endtask : t_pin
  initial begin
    clk = 1'b0;
    fsc = 1'b0;
    run = 1'b0;
    port_data = 1'b0;
    port_dir = 1'b0;
    lvl = 1'b1;
    req = '0;
    sys_rst = 1'b1;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_up();
    t_prescale();
    t_center();
    t_clocks();
    t_pin();
    wrap_up();
  end
endmodule : tb
`default_nettype wire

// File: timer_core_consts.svh
// Constants for the timer/PWM counter core.
`ifndef TIMER_CORE_CONSTS_SVH
`define TIMER_CORE_CONSTS_SVH
`define ADDR_CTRL_STATUS 3'h0
`define ADDR_COUNT_HI 3'h1
`define ADDR_COUNT_LO 3'h2
`define ADDR_MOD_HI 3'h3
`define ADDR_MOD_LO 3'h4
`define ADDR_CHAN_CTRL 3'h5
`define BIT_OVF 7
`define BIT_OVF_IE 6
`define BIT_CENTER_ALIGNED_PWM 5
`define CLKS_HI 4
`define CLKS_LO 3
`define PS_HI 2
`define PS_LO 0
`define CLKS_NONE 2'h0
`define CLKS_BUS 2'h1
`define CLKS_FIXED 2'h2
`define CLKS_EXT 2'h3
`define CTRL_RESET 8'h00
`define COUNT_RESET 16'h0000
`define MOD_RESET 16'h0000
`define MOD_ALL_ONES 16'hffff
`define COUNT_ONE 16'h0001
`define PRE_ONE 7'h01
`define ELS_NONE 2'h0
`define CHAN_FLAG_BIT 7
`define CHAN_MODE_HI 3
`define CHAN_MODE_LO 2
`define CHAN_EDGE_HI 1
`define CHAN_EDGE_LO 0
`define EDGE_RISE_BIT 0
`define EDGE_FALL_BIT 1
`define MODE_CAPTURE 2'h0
`endif

// File: timer_core_pkg.sv
// Types shared by the timer/PWM counter core.
package timer_core_pkg;
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
  typedef struct packed {
    logic ovf;
    logic ovf_ie;
    logic center_aligned_pwm;
    logic [1:0] clks;
    logic [2:0] ps;
  } ctrl_t;
  typedef enum logic {
    ST_IDLE,
    ST_ARMED
  } clr_state_t;
endpackage : timer_core_pkg

// File: timer_core_sva.sv
// Checker for the timer/PWM counter core.
`timescale 1ns/1ps
`default_nettype none
module timer_core_sva #(
  parameter int CNT_W = 16
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Register writes.
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  // Pin and status.
  input wire logic port_data,
  input wire logic port_dir,
  input wire logic channel_pin_out,
  input wire logic channel_pin_oe,
  input wire logic [CNT_W-1:0] counter_value,
  input wire logic overflow_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic [6:0] ctl_q;
  logic [2:0] idl_q;
  logic calm;
  logic up1;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctl_q <= 7'h00;
    end else if (reg_wr && reg_addr == 3'h0) begin
      ctl_q <= reg_wdata[6:0];
    end
  end
  // Quiet cycles since the last write, so that settling after a write is excused.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      idl_q <= 3'h0;
    end else if (reg_wr) begin
      idl_q <= 3'h0;
    end else if (idl_q != 3'h7) begin
      idl_q <= idl_q + 3'h1;
    end
  end
  assign calm = idl_q > 3'h3;
  assign up1 = calm && ctl_q[5:0] == 6'h08;
  a_cnt_clear: assert property (reg_wr && reg_addr inside {3'h1, 3'h2}
    |-> ##[1:3] counter_value == '0) else $error("counter not cleared");
  a_off_still: assert property (calm && ctl_q[4:3] == 2'h0 |-> $stable(counter_value))
    else $error("counter moved while off");
  a_pin_release: assert property (calm && ctl_q[4:3] == 2'h0 && $stable(port_dir) && $stable(port_data)
    |-> channel_pin_oe == port_dir && channel_pin_out == port_data) else $error("pin not released");
  a_irq_gate: assert property (calm && !ctl_q[6] |-> !overflow_irq)
    else $error("irq while disabled");
  a_up_step: assert property (up1 |-> counter_value == $past(counter_value) + 1'b1 || counter_value == '0)
    else $error("bad up step");
  a_div_two: assert property (calm && ctl_q[5:0] == 6'h09 && $changed(counter_value) |=> $stable(counter_value))
    else $error("divide by two too fast");
  a_wrap_flag: assert property (up1 && ctl_q[6] && counter_value == '0 && $past(counter_value) != '0
    |-> ##[0:3] overflow_irq) else $error("wrap without flag");
  a_center_step: assert property (calm && ctl_q[5:0] == 6'h28
    |-> counter_value == $past(counter_value) + 1'b1 || counter_value == $past(counter_value) - 1'b1)
    else $error("bad up/down step");
  c_wrap: cover property (up1 && overflow_irq);
  c_down: cover property (calm && ctl_q[5] && counter_value < $past(counter_value));
  c_own: cover property (channel_pin_oe && !port_dir);
endmodule : timer_core_sva
bind timer_pwm_counter_core timer_core_sva #(.CNT_W(CNT_W)) timer_core_sva_inst (
  .clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .port_data, .port_dir,
  .channel_pin_out, .channel_pin_oe, .counter_value, .overflow_irq
);
`default_nettype wire

// File: timer_pwm_counter_core.sv
// Counter core of a 16-bit timer/PWM module with its control/status register.
// Register map, one byte per address:
// 0 control/status: [7] overflow flag, [6] overflow interrupt enable,
//   [5] center-aligned select, [4:3] clock source, [2:0] prescale.
// 1 counter high byte and 2 counter low byte; a write to either clears the count.
// 3 modulo high byte and 4 modulo low byte; the two bytes are held independently.
// 5 channel control: [7] channel flag, [3:2] mode, [1:0] edge/level.
// Addresses 6 and 7 read as zero and ignore writes.
//
// Timing:
// Every output is registered, so the counter copy lags the live count by a cycle.
// Read data stand for exactly one cycle after the read strobe and are zero otherwise.
// A pin clock is seen a few bus cycles late because of its synchroniser.
// Known limits: counter reads are not latched and modulo bytes are not buffered,
// so software must take care when it reads or changes a running 16-bit value.
//
// Added by the designer: the register offsets and the address-and-strobe port.
`include "timer_core_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module timer_pwm_counter_core
  import timer_core_pkg::*;
#(
  parameter int CNT_W = 16
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Register port.
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Clock sources.
  input wire logic fixed_system_clock,
  input wire logic external_timer_clock,
  // Port logic and pin.
  input wire logic port_data,
  input wire logic port_dir,
  input wire logic channel_pin_in,
  output logic channel_pin_out,
  output logic channel_pin_oe,
  // Counter state and interrupts.
  output logic [CNT_W-1:0] counter_value,
  output logic overflow_irq,
  output logic channel_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus request and configuration.
  reg_req_t req;
  ctrl_t ctrl_q;
  clr_state_t clr_q;
  // Counter, modulo and prescaler state.
  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] modulo_q;
  logic down_q;
  logic [6:0] pre_q;
  // Clock synchronisers, three flops each.
  logic ext_s1_q, ext_s2_q, ext_s3_q;
  logic fix_s1_q, fix_s2_q, fix_s3_q;
  // Channel state.
  logic [3:0] chan_ctrl_q;
  logic chan_flag_q;
  logic pin_prev_q;
  // Internal strobes and levels.
  logic src_tick, count_tick, ovf_event, count_wr, ctrl_wr, pin_owned;
  logic capture_hit, pwm_level;
  logic [6:0] pre_mask;
  logic [CNT_W-1:0] mod_eff;

  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  // Mask of prescaler bits that must be all ones for a tick.
  function automatic logic [6:0] div_mask(input logic [2:0] ps);
    div_mask = 7'((8'h01 << ps) - 8'h01);
  endfunction : div_mask

  // True when the request writes the given address.
  function automatic logic hit(input reg_req_t r, input logic [2:0] a);
    hit = r.wr && (r.addr == a);
  endfunction : hit

  assign count_wr = hit(req, `ADDR_COUNT_HI) || hit(req, `ADDR_COUNT_LO);
  assign ctrl_wr = hit(req, `ADDR_CTRL_STATUS);

  ////////////////////////////////////////////////////////////////////////////
  // External and fixed clocks are synchronized; only stage two and three feed edge detection.
  // Stage three only delays stage two, so a rising edge becomes a one-cycle pulse.
  // A pin clock must stay below a quarter of the bus rate, or edges are lost
  // between two samples and the count falls behind.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
      fix_s1_q <= 1'b0;
      fix_s2_q <= 1'b0;
      fix_s3_q <= 1'b0;
    end else begin
      ext_s1_q <= external_timer_clock;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
      fix_s1_q <= fixed_system_clock;
      fix_s2_q <= fix_s1_q;
      fix_s3_q <= fix_s2_q;
    end
  end

  always_comb begin
    case (ctrl_q.clks)
      `CLKS_BUS: src_tick = 1'b1;
      `CLKS_FIXED: src_tick = fix_s2_q && !fix_s3_q;
      `CLKS_EXT: src_tick = ext_s2_q && !ext_s3_q;
      default: src_tick = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler sits after the source selection.
  // It advances once per source tick, and the counter moves when all low bits
  // picked by the divisor are ones, so the divisor is always a power of two.
  // A counter write or a stopped clock restarts it from zero.
  assign pre_mask = div_mask(ctrl_q.ps);
  assign count_tick = src_tick && ((pre_q & pre_mask) == pre_mask);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pre_q <= '0;
    end else if (count_wr || ctrl_q.clks == `CLKS_NONE) begin
      pre_q <= '0;
    end else if (src_tick) begin
      pre_q <= pre_q + `PRE_ONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter.
  // A modulo of zero acts as all ones, so both values give a free-running count.
  assign mod_eff = (modulo_q == `MOD_RESET) ? `MOD_ALL_ONES : modulo_q;

  // Overflow event: the wrap to zero when counting up, or the first step down
  // from the modulo value when center-aligned.
  always_comb begin
    ovf_event = 1'b0;
    if (count_tick && !count_wr) begin
      if (ctrl_q.center_aligned_pwm) begin
        ovf_event = !down_q && (count_q >= mod_eff);
      end else begin
        ovf_event = (count_q >= mod_eff);
      end
    end
  end

  // A counter write wins over a tick in the same cycle, so the count restarts at
  // zero whatever the data. In center-aligned mode the counter turns at the
  // modulo value and at zero; a count found above the modulo after a modulo
  // change turns down at once instead of running round the full range.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_q <= `COUNT_RESET;
      down_q <= 1'b0;
    end else if (count_wr) begin
      count_q <= `COUNT_RESET;
      down_q <= 1'b0;
    end else if (count_tick) begin
      if (ctrl_q.center_aligned_pwm) begin
        if (!down_q && count_q >= mod_eff) begin
          down_q <= 1'b1;
          count_q <= count_q - `COUNT_ONE;
        end else if (down_q && count_q == `COUNT_RESET) begin
          down_q <= 1'b0;
          count_q <= `COUNT_ONE;
        end else if (down_q) begin
          count_q <= count_q - `COUNT_ONE;
        end else begin
          count_q <= count_q + `COUNT_ONE;
        end
      end else begin
        down_q <= 1'b0;
        count_q <= (count_q >= mod_eff) ? `COUNT_RESET : count_q + `COUNT_ONE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control/status register. The flag is set by hardware and cleared only by
  // the read-then-write-zero sequence; a set in the same cycle as the clearing
  // write wins, so an overflow is never lost.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_q <= ctrl_t'(`CTRL_RESET);
    end else begin
      if (ctrl_wr) begin
        ctrl_q.ovf_ie <= req.wdata[`BIT_OVF_IE];
        ctrl_q.center_aligned_pwm <= req.wdata[`BIT_CENTER_ALIGNED_PWM];
        ctrl_q.clks <= req.wdata[`CLKS_HI:`CLKS_LO];
        ctrl_q.ps <= req.wdata[`PS_HI:`PS_LO];
      end
      if (ovf_event) begin
        ctrl_q.ovf <= 1'b1;
      end else if (ctrl_wr && clr_q == ST_ARMED && !req.wdata[`BIT_OVF]) begin
        ctrl_q.ovf <= 1'b0;
      end
    end
  end

  // Clear sequence: a status read with the flag set arms it, and any control
  // write or a fresh overflow disarms it again.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      clr_q <= ST_IDLE;
    end else begin
      case (clr_q)
        ST_IDLE: begin
          if (req.rd && req.addr == `ADDR_CTRL_STATUS && ctrl_q.ovf && !ovf_event) begin
            clr_q <= ST_ARMED;
          end
        end
        ST_ARMED: begin
          if (ovf_event || ctrl_wr) begin
            clr_q <= ST_IDLE;
          end
        end
        default: clr_q <= ST_IDLE;
      endcase
    end
  end

  // Modulo bytes load straight from the bus. Changing them while the counter
  // runs may leave the count above the new value, so it wraps or turns down at once; software should clear the
  // counter first when the next overflow time matters.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      modulo_q <= `MOD_RESET;
    end else if (hit(req, `ADDR_MOD_HI)) begin
      modulo_q[15:8] <= req.wdata;
    end else if (hit(req, `ADDR_MOD_LO)) begin
      modulo_q[7:0] <= req.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Minimal channel: [3:2] mode, [1:0] edge/level; flag sets on a capture edge unless center-aligned.
  // The pin belongs to the timer only while the module runs and the edge/level
  // field asks for a pin function; otherwise the port logic keeps it.
  // Capture edges are judged against the previous pin sample, which tracks the
  // pin even while the channel is idle, so no stale edge shows up later.
  assign pin_owned = (ctrl_q.clks != `CLKS_NONE) &&
                     (chan_ctrl_q[`CHAN_EDGE_HI:`CHAN_EDGE_LO] != `ELS_NONE);
  assign capture_hit = pin_owned && (chan_ctrl_q[`CHAN_MODE_HI:`CHAN_MODE_LO] == `MODE_CAPTURE) &&
                       !ctrl_q.center_aligned_pwm &&
                       ((chan_ctrl_q[`EDGE_RISE_BIT] && channel_pin_in && !pin_prev_q) ||
                        (chan_ctrl_q[`EDGE_FALL_BIT] && !channel_pin_in && pin_prev_q));
  assign pwm_level = chan_ctrl_q[`CHAN_MODE_HI] &&
                     ((count_q < modulo_q) ^ chan_ctrl_q[`EDGE_RISE_BIT]);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_prev_q <= 1'b0;
    end else begin
      pin_prev_q <= channel_pin_in;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      chan_ctrl_q <= '0;
    end else if (hit(req, `ADDR_CHAN_CTRL)) begin
      chan_ctrl_q <= req.wdata[`CHAN_MODE_HI:`CHAN_EDGE_LO];
    end
  end

  // The channel flag follows the same rule as the overflow flag: set wins.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      chan_flag_q <= 1'b0;
    end else if (capture_hit) begin
      chan_flag_q <= 1'b1;
    end else if (hit(req, `ADDR_CHAN_CTRL) && !req.wdata[`CHAN_FLAG_BIT]) begin
      chan_flag_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs.
  // Copy of the counter, one cycle behind the live count.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      counter_value <= '0;
    end else begin
      counter_value <= count_q;
    end
  end

  // Interrupt levels, one per channel plus the overflow.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      overflow_irq <= 1'b0;
      channel_irq <= 1'b0;
    end else begin
      overflow_irq <= ctrl_q.ovf && ctrl_q.ovf_ie;
      channel_irq <= chan_flag_q;
    end
  end

  // Pin drive. While the timer owns the pin the port settings are ignored;
  // otherwise the port logic drives it, which after reset means input only.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      channel_pin_out <= 1'b0;
      channel_pin_oe <= 1'b0;
    end else if (pin_owned) begin
      channel_pin_oe <= chan_ctrl_q[`CHAN_MODE_HI];
      channel_pin_out <= pwm_level;
    end else begin
      channel_pin_oe <= port_dir;
      channel_pin_out <= port_data;
    end
  end

  // Read data stand for one cycle after the read strobe and are zero otherwise.
  // Reading never disturbs the count or any flag.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= '0;
      if (req.rd) begin
        if (req.addr == `ADDR_CTRL_STATUS) begin
          reg_rdata <= {ctrl_q.ovf, ctrl_q.ovf_ie, ctrl_q.center_aligned_pwm, ctrl_q.clks, ctrl_q.ps};
        end else if (req.addr == `ADDR_COUNT_HI) begin
          reg_rdata <= count_q[15:8];
        end else if (req.addr == `ADDR_COUNT_LO) begin
          reg_rdata <= count_q[7:0];
        end else if (req.addr == `ADDR_MOD_HI) begin
          reg_rdata <= modulo_q[15:8];
        end else if (req.addr == `ADDR_MOD_LO) begin
          reg_rdata <= modulo_q[7:0];
        end else if (req.addr == `ADDR_CHAN_CTRL) begin
          reg_rdata <= {chan_flag_q, 3'h0, chan_ctrl_q};
        end
      end
    end
  end

endmodule : timer_pwm_counter_core
`default_nettype wire
